// ==== dtfm_pkg.sv ====
package dtfm_pkg;

  localparam int CODE_W = 14;
  localparam int TERM_N = 3;
  typedef logic [CODE_W-1:0] dtfm_code_t;

  ////////////////////////////////////////////////////////////////////////////
  // Output selection codes, positive logic, plus the negative-logic range and the no-function code
  localparam dtfm_code_t SEL_RUNNING = 14'h0000;
  localparam dtfm_code_t SEL_UP_TO_SPEED = 14'h0001;
  localparam dtfm_code_t SEL_OVERLOAD = 14'h0003;
  localparam dtfm_code_t SEL_FREQ_DETECT = 14'h0004;
  localparam dtfm_code_t SEL_REGEN_PRE = 14'h0007;
  localparam dtfm_code_t SEL_THERMAL_PRE = 14'h0008;
  localparam dtfm_code_t SEL_READY = 14'h000B;
  localparam dtfm_code_t SEL_OVERCURRENT = 14'h000C;
  localparam dtfm_code_t SEL_ZERO_CURRENT = 14'h000D;
  localparam dtfm_code_t SEL_PID_LOW = 14'h000E;
  localparam dtfm_code_t SEL_PID_HIGH = 14'h000F;
  localparam dtfm_code_t SEL_PID_FORWARD = 14'h0010;
  localparam dtfm_code_t SEL_BRAKE_RELEASE = 14'h0014;
  localparam dtfm_code_t SEL_FAN_FAULT = 14'h0019;
  localparam dtfm_code_t SEL_HEATSINK_PRE = 14'h001A;
  localparam dtfm_code_t SEL_POWERLOSS = 14'h002E;
  localparam dtfm_code_t SEL_PID_ACTIVE = 14'h002F;
  localparam dtfm_code_t SEL_RETRY = 14'h0040;
  localparam dtfm_code_t SEL_FAULT = 14'h0063;
  localparam dtfm_code_t SEL_POS_MAX = 14'h0063;
  localparam dtfm_code_t SEL_NEG_OFS = 14'h0064;
  localparam dtfm_code_t SEL_NEG_MAX = 14'h00C7;
  localparam dtfm_code_t SEL_NO_FUNC = 14'h270F;

  // Reset values of the three selections
  localparam dtfm_code_t INIT_OC1 = 14'h0000;
  localparam dtfm_code_t INIT_OC2 = 14'h0004;
  localparam dtfm_code_t INIT_RELAY = 14'h0063;

  ////////////////////////////////////////////////////////////////////////////
  // Stop selection ranges
  localparam dtfm_code_t STOP_A_MAX = 14'h0064;
  localparam dtfm_code_t STOP_B_MIN = 14'h03E8;
  localparam dtfm_code_t STOP_B_MAX = 14'h044C;
  localparam dtfm_code_t STOP_B_ALT = 14'h22B8;
  localparam dtfm_code_t STOP_A_ALT = 14'h270F;

  typedef enum logic [1:0] {
    DTFM_CMD_STOP = 2'b00,
    DTFM_CMD_FWD = 2'b01,
    DTFM_CMD_REV = 2'b10
  } dtfm_cmd_t;

  typedef struct packed {
    logic fwd;
    logic rev;
    logic jog;
    logic stop;
    logic inhibit;
  } dtfm_pins_t;

  typedef struct packed {
    logic running;
    logic up_to_speed_flag;
    logic overload_alarm_flag;
    logic freq_detect_flag;
    logic regen_brake_prealarm;
    logic thermal_prealarm;
    logic operation_ready_flag;
    logic overcurrent_detect_flag;
    logic zero_current_flag;
    logic pid_low_limit_flag;
    logic pid_high_limit_flag;
    logic pid_forward_flag;
    logic brake_release_request;
    logic fan_fault;
    logic heatsink_prealarm;
    logic powerloss_decel_flag;
    logic pid_active;
    logic retry_active_flag;
    logic fault_flag;
  } dtfm_flags_t;

  typedef struct packed {
    dtfm_code_t first_open_collector_select;
    dtfm_code_t second_open_collector_select;
    dtfm_code_t relay_output_select;
  } dtfm_sel_t;

endpackage

// ==== dtfm_mux.sv ====
`timescale 1ns/1ps

// Summary of operation
// [R1] While jog input is active the three-wire stop input is ignored.
// [R2] Output inhibit shuts output off but keeps the self-hold latch.
// [R3] Stop selection picks two-start or start-plus-direction decoding.
// [R4] Two open-collector and one relay output; reset codes 0, 4, 99.
// [R5] Codes 0-99 drive flag direct; 100-199 drive flag inverted.
// [R6] Code 0 selects the running flag.
// [R7] Code 1 selects the up-to-speed flag.
// [R8] Code 3 selects the overload alarm flag.
// [R9] Code 4 selects the frequency detection flag.
// [R10] Code 7 selects the regenerative brake pre-alarm.
// [R11] Code 8 selects the thermal pre-alarm.
// [R12] Code 11 selects the operation ready flag.
// [R13] Code 12 selects the output current detection flag.
// [R14] Code 13 selects the zero current flag.
// [R15] Codes 14, 15, 16 select PID low, high and forward flags.
// [R16] Code 20 selects the brake release request.
// [R17] Code 25 selects the cooling fan fault flag.
// [R18] Code 26 selects the heatsink pre-alarm.
// [R19] Code 46 selects the power-loss deceleration flag.
// [R20] Code 47 selects the PID-active flag.
// [R21] Code 64 selects the retry-active flag.
// [R22] Code 9999 or any unlisted code keeps the terminal off.
// [R23] Terminal outputs registered; new code acts at the next edge.
module dtfm_mux
  import dtfm_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic forward_start_input_i,
  input wire logic reverse_start_input_i,
  input wire logic jog_input_i,
  input wire logic stop_input_i,
  input wire logic output_inhibit_input_i,
  input wire dtfm_code_t stop_select_setting_i,
  input wire logic sel_load_i,
  input wire dtfm_sel_t sel_i,
  input wire dtfm_flags_t status_flags_i,
  output dtfm_cmd_t run_cmd_o,
  output logic output_shutoff_o,
  output logic self_hold_o,
  output logic coast_stop_o,
  output logic [TERM_N-1:0] terminal_conduct_o
);

  typedef struct packed {
    dtfm_pins_t pin_m;
    dtfm_pins_t pin_s;
    logic hold_fwd;
    logic hold_rev;
    dtfm_cmd_t cmd;
    logic shutoff;
    logic self_hold;
    logic coast;
    logic [TERM_N-1:0] term;
    dtfm_code_t [TERM_N-1:0] sel;
  } dtfm_state_t;

  dtfm_state_t state_q;
  dtfm_state_t state_d;
  dtfm_pins_t pins_raw;
  logic stop3;
  logic mode_b;
  logic fwd_e;
  logic rev_e;

  ////////////////////////////////////////////////////////////////////////////
  // Decoders

  function automatic logic stop_mode_b(input dtfm_code_t s);
    stop_mode_b = ((s >= STOP_B_MIN) && (s <= STOP_B_MAX)) ||
                  (s == STOP_B_ALT); // [R3]
  endfunction

  function automatic logic stop_coast(input dtfm_code_t s);
    stop_coast = (s <= STOP_A_MAX) ||
                 ((s >= STOP_B_MIN) && (s <= STOP_B_MAX));
  endfunction

  function automatic dtfm_cmd_t decode_cmd(input logic f, input logic r,
                                           input logic b);
    if (b)
    begin
      if (!f)
        decode_cmd = DTFM_CMD_STOP; // [R3]
      else if (r)
        decode_cmd = DTFM_CMD_REV; // [R3]
      else
        decode_cmd = DTFM_CMD_FWD; // [R3]
    end
    else
    begin
      if (f && !r)
        decode_cmd = DTFM_CMD_FWD; // [R3]
      else if (r && !f)
        decode_cmd = DTFM_CMD_REV; // [R3]
      else
        decode_cmd = DTFM_CMD_STOP; // [R3]
    end
  endfunction

  // Result is the conducting state of one terminal
  function automatic logic term_conduct(input dtfm_code_t code,
                                        input dtfm_flags_t fl);
    logic neg;
    logic valid;
    logic lvl;
    dtfm_code_t base;
    neg = (code >= SEL_NEG_OFS); // [R5]
    base = neg ? dtfm_code_t'(code - SEL_NEG_OFS) : code; // [R5]
    valid = (code <= SEL_NEG_MAX); // [R22]
    lvl = 1'b0;
    case (base)
      SEL_RUNNING: lvl = fl.running; // [R6]
      SEL_UP_TO_SPEED: lvl = fl.up_to_speed_flag; // [R7]
      SEL_OVERLOAD: lvl = fl.overload_alarm_flag; // [R8]
      SEL_FREQ_DETECT: lvl = fl.freq_detect_flag; // [R9]
      SEL_REGEN_PRE: lvl = fl.regen_brake_prealarm; // [R10]
      SEL_THERMAL_PRE: lvl = fl.thermal_prealarm; // [R11]
      SEL_READY: lvl = fl.operation_ready_flag; // [R12]
      SEL_OVERCURRENT: lvl = fl.overcurrent_detect_flag; // [R13]
      SEL_ZERO_CURRENT: lvl = fl.zero_current_flag; // [R14]
      SEL_PID_LOW: lvl = fl.pid_low_limit_flag; // [R15]
      SEL_PID_HIGH: lvl = fl.pid_high_limit_flag; // [R15]
      SEL_PID_FORWARD: lvl = fl.pid_forward_flag; // [R15]
      SEL_BRAKE_RELEASE: lvl = fl.brake_release_request; // [R16]
      SEL_FAN_FAULT: lvl = fl.fan_fault; // [R17]
      SEL_HEATSINK_PRE: lvl = fl.heatsink_prealarm; // [R18]
      SEL_POWERLOSS: lvl = fl.powerloss_decel_flag; // [R19]
      SEL_PID_ACTIVE: lvl = fl.pid_active; // [R20]
      SEL_RETRY: lvl = fl.retry_active_flag; // [R21]
      SEL_FAULT: lvl = fl.fault_flag; // [R4]
      default: valid = 1'b0; // [R22]
    endcase
    // Negative logic still needs a listed function to conduct
    term_conduct = valid && (lvl ^ neg); // [R5] [R22]
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  assign pins_raw = '{fwd: forward_start_input_i,
                      rev: reverse_start_input_i,
                      jog: jog_input_i,
                      stop: stop_input_i,
                      inhibit: output_inhibit_input_i};

  always_comb
  begin
    state_d = state_q;
    state_d.pin_m = pins_raw;
    state_d.pin_s = state_q.pin_m;
    stop3 = state_q.pin_s.stop && !state_q.pin_s.jog; // [R1]
    mode_b = stop_mode_b(stop_select_setting_i);
    // Inhibit is not part of the clear term on purpose
    if (state_q.pin_s.jog)
    begin
      state_d.hold_fwd = state_q.hold_fwd; // [R1]
      state_d.hold_rev = state_q.hold_rev; // [R1]
    end
    else if (!state_q.pin_s.stop)
    begin
      state_d.hold_fwd = 1'b0; // [R2]
      state_d.hold_rev = 1'b0;
    end
    else if (state_q.pin_s.fwd)
    begin
      state_d.hold_fwd = 1'b1;
      state_d.hold_rev = 1'b0;
    end
    else if (state_q.pin_s.rev)
    begin
      state_d.hold_fwd = 1'b0;
      state_d.hold_rev = 1'b1;
    end
    fwd_e = state_q.pin_s.fwd || (stop3 && state_q.hold_fwd);
    rev_e = state_q.pin_s.rev || (stop3 && state_q.hold_rev);
    state_d.cmd = decode_cmd(fwd_e, rev_e, mode_b); // [R3]
    state_d.shutoff = state_q.pin_s.inhibit; // [R2]
    state_d.self_hold = state_d.hold_fwd || state_d.hold_rev;
    state_d.coast = stop_coast(stop_select_setting_i);
    if (sel_load_i)
    begin
      state_d.sel[0] = sel_i.first_open_collector_select; // [R4]
      state_d.sel[1] = sel_i.second_open_collector_select; // [R4]
      state_d.sel[2] = sel_i.relay_output_select; // [R4]
    end
    // Uses the new code so a load shows on the same edge
    for (int i = 0; i < TERM_N; i++)
    begin
      state_d.term[i] = term_conduct(state_d.sel[i], status_flags_i); // [R23]
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      state_q <= '0;
      state_q.sel <= {INIT_RELAY, INIT_OC2, INIT_OC1}; // [R4]
    end
    else
    begin
      state_q <= state_d; // [R23]
    end
  end

  assign run_cmd_o = state_q.cmd;
  assign output_shutoff_o = state_q.shutoff;
  assign self_hold_o = state_q.self_hold;
  assign coast_stop_o = state_q.coast;
  assign terminal_conduct_o = state_q.term;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_b_i);

  sequence s_fwd_steady;
    (forward_start_input_i && !reverse_start_input_i && !stop_input_i &&
     !jog_input_i && !stop_mode_b(stop_select_setting_i)) [*4];
  endsequence

  sequence s_rev_pair_b;
    (forward_start_input_i && reverse_start_input_i && !stop_input_i &&
     stop_mode_b(stop_select_setting_i)) [*4];
  endsequence

  chk_jog_stop_ignored: // [R1]
    assert property ((state_q.pin_s.jog && state_q.self_hold) |=>
                     state_q.self_hold)
    else $error("self-hold lost while jog active");

  chk_inhibit_keeps: // [R2]
    assert property ((state_q.pin_s.inhibit && state_q.pin_s.stop &&
                      state_q.self_hold) |=> state_q.self_hold)
    else $error("inhibit cleared the self-hold");

  chk_shutoff_follow: // [R2]
    assert property (output_shutoff_o == $past(state_q.pin_s.inhibit))
    else $error("shutoff does not follow inhibit");

  chk_two_start_fwd: // [R3]
    assert property (s_fwd_steady |-> run_cmd_o == DTFM_CMD_FWD)
    else $error("forward alone did not command forward");

  chk_start_dir_rev: // [R3]
    assert property (s_rev_pair_b |-> run_cmd_o == DTFM_CMD_REV)
    else $error("both inputs in direction mode not reverse");

  chk_both_stop_a: // [R3]
    assert property ((!stop3 && state_q.pin_s.fwd && state_q.pin_s.rev &&
                      !mode_b) |=> run_cmd_o == DTFM_CMD_STOP)
    else $error("both starts did not stop");

  chk_reset_codes: // [R4]
    assert property ($rose(rst_b_i) |-> (state_q.sel[2] == INIT_RELAY &&
                     state_q.sel[1] == INIT_OC2))
    else $error("selection codes wrong after reset");

  chk_pos_running: // [R6]
    assert property ((!sel_load_i && state_q.sel[0] == SEL_RUNNING) |=>
                     terminal_conduct_o[0] == $past(status_flags_i.running))
    else $error("running code does not follow flag");

  chk_neg_running: // [R5]
    assert property ((!sel_load_i && state_q.sel[0] == SEL_NEG_OFS) |=>
                     terminal_conduct_o[0] != $past(status_flags_i.running))
    else $error("negative code is not inverted");

  chk_relay_fault: // [R4]
    assert property ((!sel_load_i && state_q.sel[2] == SEL_FAULT) |=>
                     terminal_conduct_o[2] == $past(status_flags_i.fault_flag))
    else $error("relay does not follow fault");

  chk_no_func_off: // [R22]
    assert property ((sel_load_i && sel_i.first_open_collector_select ==
                      SEL_NO_FUNC) |=> !terminal_conduct_o[0])
    else $error("code 9999 terminal conducts");

  chk_load_next_edge: // [R23]
    assert property (sel_load_i |=> state_q.sel[1] ==
                     $past(sel_i.second_open_collector_select))
    else $error("selection load missed");

  chk_reset_first: // [R4]
    assert property ($rose(rst_b_i) |-> state_q.sel[0] == INIT_OC1)
    else $error("first selection code wrong after reset");

  chk_oc2_freq: // [R9]
    assert property ((!sel_load_i && state_q.sel[1] == SEL_FREQ_DETECT) |=>
                     terminal_conduct_o[1] ==
                     $past(status_flags_i.freq_detect_flag))
    else $error("frequency code does not follow flag");

  chk_relay_inverted: // [R5]
    assert property ((sel_load_i && sel_i.relay_output_select == SEL_NEG_MAX)
                     |=> terminal_conduct_o[2] !=
                     $past(status_flags_i.fault_flag))
    else $error("inverted fault code is not inverted");

  chk_relay_invalid: // [R22]
    assert property ((sel_load_i && sel_i.relay_output_select > SEL_NEG_MAX)
                     |=> !terminal_conduct_o[2])
    else $error("out of range code lets relay conduct");

  chk_jog_no_hold: // [R1]
    assert property ((state_q.pin_s.jog && !state_q.pin_s.fwd &&
                      !state_q.pin_s.rev) |=> run_cmd_o == DTFM_CMD_STOP)
    else $error("held start used while jog active");

  chk_stop_clears_hold: // [R1]
    assert property ((!state_q.pin_s.jog && !state_q.pin_s.stop) |=>
                     !self_hold_o)
    else $error("stop input did not clear the self-hold");

  chk_mode_b_stop: // [R3]
    assert property ((!fwd_e && mode_b) |=> run_cmd_o == DTFM_CMD_STOP)
    else $error("direction mode without start did not stop");

  chk_two_start_rev: // [R3]
    assert property ((!fwd_e && rev_e && !mode_b) |=>
                     run_cmd_o == DTFM_CMD_REV)
    else $error("reverse alone did not command reverse");

  // Hold is read one cycle late, hence the two-step pulse
  sequence s_fwd_pulse_held;
    (state_q.pin_s.stop && !state_q.pin_s.jog && state_q.pin_s.fwd &&
     !state_q.pin_s.rev) ##1
    (state_q.pin_s.stop && !state_q.pin_s.jog && !state_q.pin_s.fwd &&
     !state_q.pin_s.rev);
  endsequence

  chk_hold_after_pulse: // [R2]
    assert property (s_fwd_pulse_held |=> run_cmd_o == DTFM_CMD_FWD)
    else $error("released start was not held");

endmodule // dtfm_mux

// ==== dtfm_ctrl_model.sv ====
`timescale 1ns/1ps

// External controller: drives the start, jog, stop and inhibit pins
module dtfm_ctrl_model
  import dtfm_pkg::*;
(
  input wire logic ref_clk_i,
  input wire dtfm_pins_t req_i,
  output dtfm_pins_t pins_o
);
  // Pins move on the falling edge only, clear of the sampling edge
  always @(negedge ref_clk_i)
  begin
    pins_o <= req_i;
  end
endmodule // dtfm_ctrl_model

// ==== dtfm_mux_tb.sv ====
`timescale 1ns/1ps

module dtfm_mux_tb;
  import dtfm_pkg::*;
  logic ref_clk_i;
  logic rst_b_i;
  dtfm_pins_t req;
  dtfm_pins_t pins;
  dtfm_code_t stop_sel;
  logic sel_load;
  dtfm_sel_t sel;
  dtfm_flags_t flags;
  dtfm_cmd_t run_cmd;
  logic shutoff;
  logic hold;
  logic coast;
  logic [TERM_N-1:0] term;
  int bad_count;
  int num_checks;
  int code_tab [19] = '{0, 1, 3, 4, 7, 8, 11, 12, 13, 14, 15, 16, 20, 25,
                        26, 46, 47, 64, 99};
  int bad_tab [5] = '{2, 9999, 200, 102, 9998};
  int mode_tab [6] = '{0, 100, 9999, 1000, 1100, 8888};

  ////////////////////////////////////////////////////////////////////////////
  dtfm_ctrl_model ctrl_u (.ref_clk_i(ref_clk_i), .req_i(req), .pins_o(pins));

  dtfm_mux dut_u (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .forward_start_input_i(pins.fwd),
    .reverse_start_input_i(pins.rev),
    .jog_input_i(pins.jog),
    .stop_input_i(pins.stop),
    .output_inhibit_input_i(pins.inhibit),
    .stop_select_setting_i(stop_sel),
    .sel_load_i(sel_load),
    .sel_i(sel),
    .status_flags_i(flags),
    .run_cmd_o(run_cmd),
    .output_shutoff_o(shutoff),
    .self_hold_o(hold),
    .coast_stop_o(coast),
    .terminal_conduct_o(term)
  );

  initial
  begin
    ref_clk_i = 1'b0;
    forever #2 ref_clk_i = ~ref_clk_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk_cmd(input dtfm_cmd_t got, input dtfm_cmd_t exp);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_vec(input logic [2:0] got, input logic [2:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Two edges: load edge plus register edge, robust to either reading
  task automatic set_term(input dtfm_code_t c, input dtfm_flags_t f);
    @(negedge ref_clk_i);
    sel = '{c, c, c};
    flags = f;
    repeat (2) @(posedge ref_clk_i);
    #1;
  endtask

  // Pin path is 3 edges deep; model adds up to one more
  task automatic set_pins(input dtfm_pins_t p);
    req = p;
    repeat (5) @(posedge ref_clk_i);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    set_term(14'h0000, 19'h48000);
    chk_vec(term, 3'h3);
    set_term(14'h0000, 19'h08001);
    chk_vec(term, 3'h6);
    $display("t_reset done");
  endtask

  task automatic t_codes();
    dtfm_flags_t one;
    @(negedge ref_clk_i);
    sel_load = 1'b1;
    foreach (code_tab[i])
    begin
      one = 19'h00001 << (18 - i);
      set_term(14'(code_tab[i]), one);
      chk_vec(term, 3'h7);
      set_term(14'(code_tab[i]), ~one);
      chk_vec(term, 3'h0);
      set_term(14'(code_tab[i] + 100), one);
      chk_vec(term, 3'h0);
      set_term(14'(code_tab[i] + 100), ~one);
      chk_vec(term, 3'h7);
    end
    $display("t_codes done");
  endtask

  task automatic t_invalid();
    foreach (bad_tab[i])
    begin
      set_term(14'(bad_tab[i]), 19'h7FFFF);
      chk_vec(term, 3'h0);
      set_term(14'(bad_tab[i]), 19'h00000);
      chk_vec(term, 3'h0);
    end
    set_term(14'h0000, 19'h40000);
    chk_vec(term, 3'h7);
    @(negedge ref_clk_i);
    sel_load = 1'b0;
    // Load low: new code must not take hold
    set_term(14'h0063, 19'h40000);
    chk_vec(term, 3'h7);
    @(negedge ref_clk_i);
    sel_load = 1'b1;
    // Inverted running code must survive a low load
    set_term(14'h0064, 19'h00000);
    chk_vec(term, 3'h7);
    @(negedge ref_clk_i);
    sel_load = 1'b0;
    set_term(14'h0000, 19'h40000);
    chk_vec(term, 3'h0);
    @(negedge ref_clk_i);
    sel_load = 1'b1;
    $display("t_invalid done");
  endtask

  task automatic t_decode();
    dtfm_cmd_t exp;
    logic mode_b;
    for (int m = 0; m < 6; m++)
    begin
      @(negedge ref_clk_i);
      stop_sel = 14'(mode_tab[m]);
      mode_b = (m >= 3);
      for (int p = 0; p < 4; p++)
      begin
        set_pins('{p[1], p[0], 1'b0, 1'b0, 1'b0});
        if (mode_b)
          exp = !p[1] ? DTFM_CMD_STOP : (p[0] ? DTFM_CMD_REV : DTFM_CMD_FWD);
        else
          exp = (p == 2) ? DTFM_CMD_FWD :
                ((p == 1) ? DTFM_CMD_REV : DTFM_CMD_STOP);
        chk_cmd(run_cmd, exp);
        chk_vec({2'b00, coast}, {2'b00, mode_tab[m] != 9999 &&
                mode_tab[m] != 8888});
      end
    end
    $display("t_decode done");
  endtask

  task automatic t_three_wire();
    @(negedge ref_clk_i);
    stop_sel = 14'h270F;
    set_pins('{1'b0, 1'b1, 1'b0, 1'b1, 1'b0});
    set_pins('{1'b0, 1'b0, 1'b0, 1'b1, 1'b0});
    chk_cmd(run_cmd, DTFM_CMD_REV);
    set_pins('{1'b1, 1'b0, 1'b0, 1'b1, 1'b0});
    set_pins('{1'b0, 1'b0, 1'b0, 1'b1, 1'b1});
    chk_vec({1'b0, shutoff, hold}, 3'h3);
    set_pins('{1'b0, 1'b0, 1'b0, 1'b1, 1'b0});
    chk_cmd(run_cmd, DTFM_CMD_FWD);
    // Jog frees the stop pin; hold must survive stop going low
    set_pins('{1'b0, 1'b0, 1'b1, 1'b0, 1'b0});
    chk_vec({2'b00, hold}, 3'h1);
    set_pins('{1'b0, 1'b0, 1'b0, 1'b0, 1'b0});
    chk_vec({2'b00, hold}, 3'h0);
    chk_cmd(run_cmd, DTFM_CMD_STOP);
    $display("t_three_wire done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
    begin
      $display("SIMULATION PASSED");
    end
    else
    begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial
  begin
    #20000;
    bad_count++;
    complete_run();
  end

  initial
  begin
    rst_b_i = 1'b0;
    req = '0;
    stop_sel = 14'h270F;
    sel_load = 1'b0;
    sel = '0;
    flags = '0;
    repeat (10) @(negedge ref_clk_i);
    rst_b_i = 1'b1;
    t_reset();
    t_codes();
    t_invalid();
    t_decode();
    t_three_wire();
    complete_run();
  end
endmodule // dtfm_mux_tb
